//--- hw/stepper_move_stop_control.v
// move sequencing and stop handling for a stepper indexer
`timescale 1ns/1ps
`include "stepper_move_defs.vh"
module stepper_move_stop_control (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // host command word
  input  wire        cmd_start,
  input  wire [2:0]  cmd_code,
  input  wire        cmd_run,
  input  wire [31:0] cmd_target,
  input  wire [23:0] cmd_speed,
  input  wire [23:0] cmd_accel,
  input  wire [23:0] cmd_decel,
  // host control bits
  input  wire        hold_bit,
  input  wire        resume_bit,
  input  wire        immediate_stop_bit,
  // configuration
  input  wire [23:0] starting_speed,
  input  wire        estop_enable,
  input  wire        stop_jog_enable,
  // homing logic
  input  wire        homing_done,
  // pins
  input  wire        clockwise_end_switch,
  input  wire        counterclockwise_end_switch,
  input  wire        estop_pin,
  input  wire        stop_jog_pin,
  // motor drive
  output wire        step_pulse,
  output wire        step_dir_cw,
  // status to host
  output wire [31:0] motor_position,
  output wire [23:0] current_speed,
  output wire        position_invalid,
  output wire        in_hold,
  output wire        move_busy,
  output wire        clockwise_end_switch_error,
  output wire        counterclockwise_end_switch_error,
  output wire        cmd_refused,
  output wire        move_done
);

  localparam [4:0] ST_IDLE   = 5'h01;
  localparam [4:0] ST_ACCEL  = 5'h02;
  localparam [4:0] ST_CRUISE = 5'h04;
  localparam [4:0] ST_DECEL  = 5'h08;
  localparam [4:0] ST_HOLD   = 5'h10;
  localparam integer RAMP_LAST_I = `RAMP_TICK_CYCLES - 1;
  localparam [6:0]   RAMP_LAST   = RAMP_LAST_I[6:0];

  function free_run;
    input [2:0] kind;
    begin
      free_run = (kind == `CMD_JOG) || (kind == `CMD_REGISTRATION);
    end
  endfunction

  function hold_capable;
    input [2:0] kind;
    begin
      hold_capable = (kind == `CMD_RELATIVE) || (kind == `CMD_ABSOLUTE);
    end
  endfunction

  function [31:0] clamp_offset;
    input [31:0] v;
    begin
      if ($signed(v) > $signed(`OFFSET_MAX))
        clamp_offset = `OFFSET_MAX;
      else if ($signed(v) < $signed(`OFFSET_MIN))
        clamp_offset = `OFFSET_MIN;
      else
        clamp_offset = v;
    end
  endfunction

  // pin synchronisation and edges
  wire [3:0] pins_s;
  reg  [3:0] pin_prev_ff;
  reg  [2:0] host_prev_ff;
  wire       step_fire;

  pin_sync #(.W(4)) u_pin_sync (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .pin_in       ({stop_jog_pin, estop_pin, counterclockwise_end_switch,
                    clockwise_end_switch}),
    .pin_sync_out (pins_s)
  );

  wire sw_cw       = pins_s[0];
  wire sw_ccw      = pins_s[1];
  wire cw_rise     = pins_s[0] & ~pin_prev_ff[0];
  wire ccw_rise    = pins_s[1] & ~pin_prev_ff[1];
  wire estop_evt   = estop_enable & pins_s[2] & ~pin_prev_ff[2];
  wire stopjog_evt = stop_jog_enable & pins_s[3] & ~pin_prev_ff[3];
  wire hold_evt    = hold_bit ^ host_prev_ff[0];
  wire resume_evt  = resume_bit & ~host_prev_ff[1];
  wire istop_evt   = immediate_stop_bit & ~host_prev_ff[2];

  // state and data registers
  reg [4:0]  state_ff,      nxt_state;
  reg [2:0]  kind_ff,       nxt_kind;
  reg        dir_cw_ff,     nxt_dir_cw;
  reg [32:0] remaining_ff,  nxt_remaining;
  reg [32:0] ramp_steps_ff, nxt_ramp_steps;
  reg [23:0] speed_ff,      nxt_speed;
  reg [23:0] prog_speed_ff, nxt_prog_speed;
  reg [23:0] accel_ff,      nxt_accel;
  reg [23:0] decel_ff,      nxt_decel;
  reg        stop_ff,       nxt_stop;
  reg        to_hold_ff,    nxt_to_hold;
  reg [31:0] position_ff,   nxt_position;
  reg        pos_invalid_ff, nxt_pos_invalid;
  reg        cw_err_ff,     nxt_cw_err;
  reg        ccw_err_ff,    nxt_ccw_err;
  reg        refused_ff,    nxt_refused;
  reg        done_ff,       nxt_done;
  reg [6:0]  ramp_cnt_ff;

  wire ramp_tick = (ramp_cnt_ff == RAMP_LAST);
  wire moving    = |(state_ff & (ST_ACCEL | ST_CRUISE | ST_DECEL));

  // start decode
  wire [31:0] tgt_clamped = clamp_offset(cmd_target);
  wire [32:0] rel_dist    = {tgt_clamped[31], tgt_clamped};
  wire [32:0] abs_dist    = {tgt_clamped[31], tgt_clamped} -
                            {position_ff[31], position_ff};
  wire [32:0] sel_dist    = (cmd_code == `CMD_ABSOLUTE) ? abs_dist : rel_dist;
  wire [32:0] sel_mag     = sel_dist[32] ? (33'h000000000 - sel_dist) : sel_dist;
  wire        pos_cw      = free_run(cmd_code) ? ~cmd_target[31]
                                               : (~sel_dist[32] & (|sel_dist));
  wire        dir_blocked = pos_cw ? cw_err_ff : ccw_err_ff;
  wire        on_limit    = pos_cw ? sw_cw : sw_ccw;

  // speed arithmetic
  wire [24:0] spd_up     = {1'b0, speed_ff} + {1'b0, accel_ff};
  wire [24:0] spd_dn     = {1'b0, speed_ff} - {1'b0, decel_ff};
  wire [23:0] eff_prog   = (prog_speed_ff < starting_speed) ? starting_speed
                                                            : prog_speed_ff;
  wire        at_start   = (speed_ff <= starting_speed);
  wire        last_step  = step_fire && (remaining_ff == 33'h000000001);

  // limit stop for the current move
  wire        lim_travel = dir_cw_ff ? sw_cw : sw_ccw;
  wire        lim_oppose = dir_cw_ff ? ccw_rise : cw_rise;
  wire        limit_stop = free_run(kind_ff) ? lim_travel
                                             : (lim_travel | lim_oppose);
  wire        imm_stop   = istop_evt | estop_evt | limit_stop;

  always @* begin
    nxt_state       = state_ff;
    nxt_kind        = kind_ff;
    nxt_dir_cw      = dir_cw_ff;
    nxt_remaining   = remaining_ff;
    nxt_ramp_steps  = ramp_steps_ff;
    nxt_speed       = speed_ff;
    nxt_prog_speed  = prog_speed_ff;
    nxt_accel       = accel_ff;
    nxt_decel       = decel_ff;
    nxt_stop        = stop_ff;
    nxt_to_hold     = to_hold_ff;
    nxt_position    = position_ff;
    nxt_pos_invalid = pos_invalid_ff;
    nxt_cw_err      = cw_err_ff;
    nxt_ccw_err     = ccw_err_ff;
    nxt_refused     = 1'b0;
    nxt_done        = 1'b0;

    // position follows every emitted step
    if (step_fire) begin
      if (dir_cw_ff)
        nxt_position = position_ff + 32'h00000001;
      else
        nxt_position = position_ff - 32'h00000001;
      nxt_remaining = remaining_ff - 33'h000000001;
      if (state_ff == ST_ACCEL)
        nxt_ramp_steps = ramp_steps_ff + 33'h000000001;
    end

    // host commands taken while no move is running, reset errors at any time
    if (cmd_start) begin
      if (cmd_code == `CMD_RESET_ERRORS) begin
        nxt_cw_err  = 1'b0;
        nxt_ccw_err = 1'b0;
      end else if (moving) begin
        nxt_refused = 1'b1;
      end else if (cmd_code == `CMD_PRESET) begin
        nxt_position    = cmd_target;
        nxt_pos_invalid = 1'b0;
        nxt_state       = ST_IDLE;
      end else if (cmd_code > `CMD_REGISTRATION) begin
        nxt_refused = 1'b1;
      end else if ((cmd_code == `CMD_ABSOLUTE) && pos_invalid_ff) begin
        nxt_refused = 1'b1;
      end else if (dir_blocked || (free_run(cmd_code) && on_limit)) begin
        nxt_refused = 1'b1;
      end else if (!free_run(cmd_code) && (sel_mag == 33'h000000000)) begin
        nxt_state = ST_IDLE;
        nxt_done  = 1'b1;
      end else begin
        // a held move is simply overwritten here
        nxt_state      = ST_ACCEL;
        nxt_kind       = cmd_code;
        nxt_dir_cw     = pos_cw;
        nxt_remaining  = sel_mag;
        nxt_ramp_steps = 33'h000000000;
        nxt_speed      = starting_speed;
        nxt_prog_speed = cmd_speed;
        nxt_accel      = cmd_accel;
        nxt_decel      = cmd_decel;
        nxt_stop       = 1'b0;
        nxt_to_hold    = 1'b0;
      end
    end

    case (state_ff)
      ST_IDLE: begin
        nxt_speed = nxt_speed;
      end
      ST_ACCEL, ST_CRUISE: begin
        if (state_ff == ST_ACCEL && ramp_tick) begin
          if (spd_up[23:0] >= eff_prog || spd_up[24]) begin
            nxt_speed = eff_prog;
            nxt_state = ST_CRUISE;
          end else begin
            nxt_speed = spd_up[23:0];
          end
        end
        // ramp steps double as the distance needed to slow down
        if (!free_run(kind_ff) && (remaining_ff <= ramp_steps_ff))
          nxt_state = ST_DECEL;
        if (hold_evt) begin
          nxt_state   = ST_DECEL;
          nxt_stop    = 1'b1;
          nxt_to_hold = hold_capable(kind_ff);
        end
        if (free_run(kind_ff) && (stopjog_evt || !cmd_run)) begin
          nxt_state = ST_DECEL;
          nxt_stop  = 1'b1;
        end
      end
      ST_DECEL: begin
        if (ramp_tick) begin
          if (spd_dn[24] || spd_dn[23:0] < starting_speed)
            nxt_speed = starting_speed;
          else
            nxt_speed = spd_dn[23:0];
        end
        if (hold_evt && hold_capable(kind_ff)) begin
          nxt_stop    = 1'b1;
          nxt_to_hold = 1'b1;
        end
        if (stop_ff && at_start) begin
          nxt_state = to_hold_ff ? ST_HOLD : ST_IDLE;
          nxt_done  = ~to_hold_ff;
        end
      end
      ST_HOLD: begin
        if (resume_evt && !(cmd_start && !moving)) begin
          // remaining distance and direction are kept from the hold
          nxt_state      = ST_ACCEL;
          nxt_speed      = starting_speed;
          nxt_ramp_steps = 33'h000000000;
          nxt_prog_speed = cmd_speed;
          nxt_accel      = cmd_accel;
          nxt_decel      = cmd_decel;
          nxt_stop       = 1'b0;
          nxt_to_hold    = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase

    // the target ends any move that counts steps
    if (moving && !free_run(kind_ff) && last_step) begin
      nxt_state = ST_IDLE;
      nxt_done  = 1'b1;
    end

    // immediate stops override everything else
    if ((moving && imm_stop) || (state_ff == ST_HOLD && (istop_evt || estop_evt))) begin
      nxt_state       = ST_IDLE;
      nxt_speed       = `SPEED_RST;
      nxt_remaining   = 33'h000000000;
      nxt_to_hold     = 1'b0;
    end
    if (moving && limit_stop) begin
      if (dir_cw_ff && sw_cw)
        nxt_cw_err = 1'b1;
      if (!dir_cw_ff && sw_ccw)
        nxt_ccw_err = 1'b1;
    end

    // invalidation is applied last so it wins over preset or homing
    if (homing_done) begin
      nxt_position    = `POSITION_RST;
      nxt_pos_invalid = 1'b0;
    end
    if ((moving && imm_stop) || (state_ff == ST_HOLD && (istop_evt || estop_evt)))
      nxt_pos_invalid = 1'b1;
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff       <= ST_IDLE;
      kind_ff        <= `CMD_RELATIVE;
      dir_cw_ff      <= 1'b1;
      remaining_ff   <= 33'h000000000;
      ramp_steps_ff  <= 33'h000000000;
      speed_ff       <= `SPEED_RST;
      prog_speed_ff  <= `SPEED_RST;
      accel_ff       <= `SPEED_RST;
      decel_ff       <= `SPEED_RST;
      stop_ff        <= 1'b0;
      to_hold_ff     <= 1'b0;
      position_ff    <= `POSITION_RST;
      pos_invalid_ff <= `POS_INVALID_RST;
      cw_err_ff      <= 1'b0;
      ccw_err_ff     <= 1'b0;
      refused_ff     <= 1'b0;
      done_ff        <= 1'b0;
      ramp_cnt_ff    <= 7'h00;
      pin_prev_ff    <= 4'h0;
      host_prev_ff   <= 3'h0;
    end else begin
      state_ff       <= nxt_state;
      kind_ff        <= nxt_kind;
      dir_cw_ff      <= nxt_dir_cw;
      remaining_ff   <= nxt_remaining;
      ramp_steps_ff  <= nxt_ramp_steps;
      speed_ff       <= nxt_speed;
      prog_speed_ff  <= nxt_prog_speed;
      accel_ff       <= nxt_accel;
      decel_ff       <= nxt_decel;
      stop_ff        <= nxt_stop;
      to_hold_ff     <= nxt_to_hold;
      position_ff    <= nxt_position;
      pos_invalid_ff <= nxt_pos_invalid;
      cw_err_ff      <= nxt_cw_err;
      ccw_err_ff     <= nxt_ccw_err;
      refused_ff     <= nxt_refused;
      done_ff        <= nxt_done;
      ramp_cnt_ff    <= ramp_tick ? 7'h00 : ramp_cnt_ff + 7'h01;
      pin_prev_ff    <= pins_s;
      host_prev_ff   <= {immediate_stop_bit, resume_bit, hold_bit};
    end
  end

  // run follows the next state so the last step is never doubled
  wire gen_run = |(nxt_state & (ST_ACCEL | ST_CRUISE | ST_DECEL));

  step_rate_gen u_step_rate_gen (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .run      (gen_run),
    .speed    (speed_ff),
    .step_out (step_fire)
  );

  assign step_pulse       = step_fire;
  assign step_dir_cw      = dir_cw_ff;
  assign motor_position   = position_ff;
  assign current_speed    = speed_ff;
  assign position_invalid = pos_invalid_ff;
  assign in_hold          = state_ff[4];
  assign move_busy        = moving;
  assign clockwise_end_switch_error   = cw_err_ff;
  assign counterclockwise_end_switch_error  = ccw_err_ff;
  assign cmd_refused      = refused_ff;
  assign move_done        = done_ff;

endmodule

//--- hw/stepper_move_defs.vh
// constants shared by the stepper move and stop control block
`ifndef STEPPER_MOVE_DEFS_VH
`define STEPPER_MOVE_DEFS_VH

// clock and ramp timing
`define CLK_PERIOD_NS     8
`define CLK_HZ            (1000000000 / `CLK_PERIOD_NS)
`define RAMP_TICK_NS      1000
`define RAMP_TICK_CYCLES  (`RAMP_TICK_NS / `CLK_PERIOD_NS)

// offset and target range
`define OFFSET_MAX        32'h007fffff
`define OFFSET_MIN        32'hff800001

// command codes on cmd_code
`define CMD_RELATIVE      3'h0
`define CMD_ABSOLUTE      3'h1
`define CMD_JOG           3'h2
`define CMD_REGISTRATION  3'h3
`define CMD_PRESET        3'h4
`define CMD_RESET_ERRORS  3'h5

// reset values
`define POS_INVALID_RST   1'b1
`define POSITION_RST      32'h00000000
`define SPEED_RST         24'h000000

`endif

//--- hw/pin_sync.v
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter W = 4
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         rst,
  // pins in, synchronised levels out
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] pin_sync_out
);

  reg [W-1:0] stage1_ff;
  reg [W-1:0] stage2_ff;

  // stage1 feeds stage2 only, to keep metastability out of the logic
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_ff <= {W{1'b0}};
      stage2_ff <= {W{1'b0}};
    end else begin
      stage1_ff <= pin_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign pin_sync_out = stage2_ff;

endmodule

//--- hw/step_rate_gen.v
// step pulse generator: fractional accumulator at steps per second
`timescale 1ns/1ps
`include "stepper_move_defs.vh"
module step_rate_gen (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // rate control
  input  wire        run,
  input  wire [23:0] speed,
  // step out
  output wire        step_out
);

  reg  [31:0] acc_ff;
  reg         step_ff;
  wire [31:0] sum;

  assign sum = acc_ff + {8'h00, speed};

  // dropping run clears the phase so no stray step follows a stop
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_ff  <= 32'h00000000;
      step_ff <= 1'b0;
    end else if (!run) begin
      acc_ff  <= 32'h00000000;
      step_ff <= 1'b0;
    end else if (sum >= `CLK_HZ) begin
      acc_ff  <= sum - `CLK_HZ;
      step_ff <= 1'b1;
    end else begin
      acc_ff  <= sum;
      step_ff <= 1'b0;
    end
  end

  assign step_out = step_ff;

endmodule

//--- sim/stepper_move_stop_control_asserts.sv
// assertion checker on the move and stop control ports
`timescale 1ns/1ps
`include "stepper_move_defs.vh"
module stepper_move_stop_control_asserts (
  // clock and reset
  input wire        clk_sys,
  input wire        rst,
  // host and pins
  input wire        cmd_start,
  input wire [2:0]  cmd_code,
  input wire [31:0] cmd_target,
  input wire        immediate_stop_bit,
  input wire        homing_done,
  input wire        clockwise_end_switch,
  // outputs
  input wire        step_pulse,
  input wire        step_dir_cw,
  input wire [31:0] motor_position,
  input wire        position_invalid,
  input wire        in_hold,
  input wire        move_busy,
  input wire        clockwise_end_switch_error,
  input wire        counterclockwise_end_switch_error,
  input wire        cmd_refused
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire rel_cmd = cmd_start && cmd_code == `CMD_RELATIVE;
  wire no_err  = !clockwise_end_switch_error && !counterclockwise_end_switch_error;
  property p_imm_stop;
    $rose(immediate_stop_bit) && move_busy |-> ##[1:3] (!move_busy && position_invalid);
  endproperty
  a_imm_stop: assert property (p_imm_stop)
    else $error("host stop did not halt");
  // preset and homing load the count, so they are left out
  property p_step;
    step_pulse && !(cmd_start && cmd_code == `CMD_PRESET) && !homing_done |=>
      motor_position == $past(motor_position) + ($past(step_dir_cw) ? 32'h1 : 32'hffffffff);
  endproperty
  a_step: assert property (p_step)
    else $error("position did not follow step");
  property p_idle;
    !move_busy [*2] |-> !step_pulse;
  endproperty
  a_idle: assert property (p_idle)
    else $error("step while stopped");
  property p_abs;
    cmd_start && cmd_code == `CMD_ABSOLUTE && position_invalid |=> cmd_refused;
  endproperty
  a_abs: assert property (p_abs)
    else $error("absolute taken while invalid");
  property p_rel;
    rel_cmd && !move_busy && no_err && cmd_target != 32'h0 |=> move_busy && !cmd_refused;
  endproperty
  a_rel: assert property (p_rel)
    else $error("relative not taken");
  property p_latch;
    move_busy && step_dir_cw && clockwise_end_switch |-> ##[1:6] clockwise_end_switch_error;
  endproperty
  a_latch: assert property (p_latch)
    else $error("travel limit not latched");
  property p_sticky;
    clockwise_end_switch_error && !(cmd_start && cmd_code == `CMD_RESET_ERRORS) |=> clockwise_end_switch_error;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("limit error lost");
  property p_block;
    clockwise_end_switch_error && rel_cmd && !cmd_target[31] && cmd_target != 32'h0 |=> cmd_refused;
  endproperty
  a_block: assert property (p_block)
    else $error("blocked direction taken");
  c_hold: cover property ($rose(in_hold));
  c_cw: cover property ($rose(clockwise_end_switch_error));
  c_ccw: cover property ($rose(counterclockwise_end_switch_error));
endmodule
bind stepper_move_stop_control stepper_move_stop_control_asserts chk_u (
  .clk_sys, .rst, .cmd_start, .cmd_code, .cmd_target, .immediate_stop_bit, .homing_done,
  .clockwise_end_switch, .step_pulse, .step_dir_cw, .motor_position, .position_invalid,
  .in_hold, .move_busy, .clockwise_end_switch_error, .counterclockwise_end_switch_error, .cmd_refused
);

//--- sim/host_ctrl_model.sv
// host controller model for the hold, resume and stop bits
`timescale 1ns/1ps
module host_ctrl_model (
  // clock
  input  wire clk_sys,
  // requests from the bench
  input  wire req_hold,
  input  wire req_resume,
  input  wire req_stop,
  // control bits
  output reg  hold_bit,
  output reg  resume_bit,
  output reg  immediate_stop_bit
);
  initial begin
    hold_bit = 1'b0;
    resume_bit = 1'b0;
    immediate_stop_bit = 1'b0;
  end
  // hold is asked by a toggle, so the level alone carries no meaning
  always @(negedge clk_sys) begin
    if (req_hold) hold_bit <= ~hold_bit;
    resume_bit <= req_resume;
    immediate_stop_bit <= req_stop;
  end
endmodule

//--- sim/stepper_move_stop_control_tb.sv
// self-checking bench for the stepper move and stop control block
`timescale 1ns/1ps
`include "stepper_move_defs.vh"
module stepper_move_stop_control_tb;
  reg         clk_sys, rst, cmd_run, cmd_start, homing_done, estop_pin, stop_jog_pin;
  reg  [2:0]  cmd_code, req;
  reg  [31:0] cmd_target;
  reg  [23:0] cmd_speed, cmd_decel, peak;
  reg  [1:0]  end_sw;
  wire        hold_bit, resume_bit, immediate_stop_bit, step_pulse, step_dir_cw;
  wire [31:0] motor_position;
  wire [23:0] current_speed;
  wire        position_invalid, in_hold, move_busy, clockwise_end_switch_error, counterclockwise_end_switch_error;
  wire        cmd_refused, move_done;
  integer     n_errors, cmp_count, model_pos, i, off;
  integer     exp_q[$];
  host_ctrl_model host_u (
    .clk_sys, .req_hold(req[0]), .req_resume(req[1]), .req_stop(req[2]), .hold_bit,
    .resume_bit, .immediate_stop_bit
  );
  stepper_move_stop_control dut_u (
    .clk_sys, .rst, .cmd_start, .cmd_code, .cmd_run, .cmd_target, .cmd_speed,
    .cmd_accel(24'h0f4240), .cmd_decel, .hold_bit, .resume_bit, .immediate_stop_bit,
    .starting_speed(24'h4c4b40), .estop_enable(1'b1), .stop_jog_enable(1'b1), .homing_done,
    .clockwise_end_switch(end_sw[0]), .counterclockwise_end_switch(end_sw[1]), .estop_pin,
    .stop_jog_pin, .step_pulse, .step_dir_cw, .motor_position, .current_speed,
    .position_invalid, .in_hold, .move_busy, .clockwise_end_switch_error, .counterclockwise_end_switch_error,
    .cmd_refused, .move_done
  );
  task check(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
        $display("[ PASS ]");
      end else begin
        $display("[ FAIL ]");
      end
      $finish;
    end
  endtask
  task send(input [2:0] code, input [31:0] tgt, input refused);
    begin
      @(negedge clk_sys);
      cmd_start <= 1'b1;
      cmd_code <= code;
      cmd_target <= tgt;
      @(negedge clk_sys);
      check({31'h0, cmd_refused}, {31'h0, refused});
      cmd_start <= 1'b0;
      @(negedge clk_sys);
    end
  endtask
  task host(input [2:0] r);
    begin
      req <= r;
      @(negedge clk_sys);
      req <= 3'h0;
    end
  endtask
  // sel 0 waits for the move to end, sel 1 for the hold state
  task wait_for(input sel, input integer lim);
    integer k;
    begin
      k = 0;
      while ((sel ? in_hold : ~move_busy) !== 1'b1 && k < lim) begin
        @(negedge clk_sys);
        k = k + 1;
        if (current_speed > peak) peak = current_speed;
      end
      if (k >= lim) begin
        check(32'h1, 32'h0);
        conclude;
      end
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    {rst, cmd_run, cmd_start, homing_done, estop_pin, stop_jog_pin} = 6'h20;
    peak = 24'h0;
    {cmd_code, req, end_sw} = 8'h0;
    cmd_target = 32'h0;
    cmd_speed = 24'h989680;
    cmd_decel = 24'h0f4240;
    {n_errors, cmp_count, model_pos} = 96'h0;
    i = $urandom(32'h5ec3ae14);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check({31'h0, position_invalid}, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      off = $urandom_range(8) - 4;
      off = (off == 0) ? 5 : off;
      exp_q.push_back(off);
      peak = 24'h0;
      send(`CMD_RELATIVE, off, 1'b0);
      wait_for(0, 2000);
      check({31'h0, move_done}, 32'h1);
      check({31'h0, peak < 24'h989680}, 32'h1);
      model_pos = model_pos + exp_q.pop_front();
      check(motor_position, model_pos);
    end
    $display("test relative done");
    send(`CMD_ABSOLUTE, 32'h10, 1'b1);
    homing_done <= 1'b1;
    @(negedge clk_sys);
    homing_done <= 1'b0;
    @(negedge clk_sys);
    check({position_invalid, motor_position[30:0]}, 32'h0);
    send(`CMD_ABSOLUTE, 32'hfffffffa, 1'b0);
    wait_for(0, 2000);
    check(motor_position, 32'hfffffffa);
    $display("test absolute done");
    for (i = 0; i < 2; i = i + 1) begin
      peak = 24'h0;
      send(`CMD_PRESET, 32'h20, 1'b0);
      send(`CMD_RELATIVE, 32'h96, 1'b0);
      repeat (300) @(negedge clk_sys);
      host(3'h1);
      wait_for(1, 3000);
      check({31'h0, position_invalid}, 32'h0);
      if (i == 1) send(`CMD_PRESET, 32'h20, 1'b0);
      cmd_speed <= 24'h7a1200;
      cmd_decel <= 24'h16e360;
      host(3'h2);
      repeat (4) @(negedge clk_sys);
      wait_for(0, 4000);
      check(motor_position, i ? 32'h20 : 32'hb6);
      if (i == 0) check(peak, 32'h7a1200);
      check({31'h0, in_hold}, 32'h0);
    end
    $display("test hold done");
    for (i = 0; i < 4; i = i + 1) begin
      send(`CMD_PRESET, 32'h0, 1'b0);
      send(`CMD_RELATIVE, i == 3 ? 32'hffffff6a : 32'h96, 1'b0);
      repeat (200) @(negedge clk_sys);
      if (i == 0) host(3'h4);
      estop_pin <= (i == 1);
      end_sw <= (i == 2) ? 2'b01 : (i == 3) ? 2'b10 : 2'b00;
      repeat (8) @(negedge clk_sys);
      check({30'h0, move_busy, position_invalid}, 32'h1);
      check({30'h0, counterclockwise_end_switch_error, clockwise_end_switch_error}, i > 1 ? i - 1 : 0);
      {estop_pin, end_sw} <= 3'h0;
      host(3'h2);
      repeat (4) @(negedge clk_sys);
      check({31'h0, move_busy}, 32'h0);
      send(`CMD_ABSOLUTE, 32'h0, 1'b1);
      if (i > 1) begin
        send(`CMD_RELATIVE, i == 3 ? 32'hfffffffb : 32'h5, 1'b1);
        send(`CMD_RELATIVE, i == 3 ? 32'h5 : 32'hfffffffb, 1'b0);
        wait_for(0, 2000);
      end
      send(`CMD_RESET_ERRORS, 32'h0, 1'b0);
      check({30'h0, counterclockwise_end_switch_error, clockwise_end_switch_error}, 32'h0);
    end
    $display("test stops done");
    send(`CMD_PRESET, 32'h0, 1'b0);
    send(`CMD_RELATIVE, 32'h28, 1'b0);
    stop_jog_pin <= 1'b1;
    wait_for(0, 2000);
    stop_jog_pin <= 1'b0;
    check({position_invalid, motor_position[30:0]}, 32'h28);
    $display("test stop input done");
    cmd_run <= 1'b1;
    send(`CMD_JOG, 32'h1, 1'b0);
    repeat (300) @(negedge clk_sys);
    check({31'h0, move_busy}, 32'h1);
    stop_jog_pin <= 1'b1;
    wait_for(0, 2000);
    check({31'h0, position_invalid}, 32'h0);
    {cmd_run, stop_jog_pin} <= 2'h0;
    $display("test jog stop done");
    conclude;
  end
endmodule
